// File: design/counter_input_config.sv
// apb register file, input filters, time base, gates and rollover counters
`timescale 1ns/1ps
// Behaviour
// - each channel's one-hot filter code picks a 50 kHz, 5 kHz, 500 Hz or 50 Hz filter, zero picks none.
// - bits 12, 13 and 14 route the A, B and index inputs through the selected filter.
// - the time base word is a millisecond count shared by both channels, never below 10 ms.
// - each channel's gate lasts its own interval word times the shared time base.
// - with limit N an up count goes from N-1 to 0 and a down count from 0 to N-1.
// - each rollover limit is held in 32 bits and software keeps it within 16,777,216 counts.
// - a channel in a rate mode ignores its rollover limit.
// - a preset load request loads each channel's counter with its own preset word.
module counter_input_config #(
	parameter int MS_CYCLES     = cnt_cfg_pkg::MS_CYCLES,
	parameter int FLT5K_CYCLES  = cnt_cfg_pkg::FLT5K_CYCLES,
	parameter int FLT500_CYCLES = cnt_cfg_pkg::FLT500_CYCLES,
	parameter int FLT50_CYCLES  = cnt_cfg_pkg::FLT50_CYCLES
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire cnt_cfg_pkg::chan_in_t [1:0] chan_in,
	output cnt_cfg_pkg::chan_in_t [1:0] chan_filtered,
	output logic      [1:0]            gate_done,
	output logic      [31:0]           count0,
	output logic      [31:0]           count1
);
	// ==========================================
	// register file
	logic [15:0] filter_reg, filter_next;
	logic [15:0] timebase_reg, timebase_next;
	logic [15:0] gate0_reg, gate0_next;
	logic [15:0] gate1_reg, gate1_next;
	logic [31:0] roll0_reg, roll0_next;
	logic [31:0] roll1_reg, roll1_next;
	logic [31:0] preset0_reg, preset0_next;
	logic [31:0] preset1_reg, preset1_next;
	logic [1:0]  mode_reg, mode_next;
	logic        load_reg, load_next;
	logic [31:0] prdata_next;
	logic        pready_next, pslverr_next;
	logic [1:0]  done_sticky_reg, done_sticky_next;
	logic        wr_go, rd_go;
	logic [7:0]  idx;
	logic        hit;
	logic [31:0] rd_val;

	assign idx   = paddr[9:2];
	assign rd_go = psel && !penable;
	assign wr_go = psel && penable && pready && pwrite && !pslverr;

	always_comb begin
		hit    = 1'b1;
		rd_val = 32'h0000_0000;
		case (idx)
			cnt_cfg_pkg::IDX_FILTER:   rd_val = {16'h0000, filter_reg};
			cnt_cfg_pkg::IDX_TIMEBASE: rd_val = {16'h0000, timebase_reg};
			cnt_cfg_pkg::IDX_GATE0:    rd_val = {16'h0000, gate0_reg};
			cnt_cfg_pkg::IDX_GATE1:    rd_val = {16'h0000, gate1_reg};
			cnt_cfg_pkg::IDX_RSVD:     rd_val = 32'h0000_0000;
			cnt_cfg_pkg::IDX_ROLL0:    rd_val = roll0_reg;
			cnt_cfg_pkg::IDX_ROLL1:    rd_val = roll1_reg;
			cnt_cfg_pkg::IDX_PRESET0:  rd_val = preset0_reg;
			cnt_cfg_pkg::IDX_PRESET1:  rd_val = preset1_reg;
			cnt_cfg_pkg::IDX_MODE:     rd_val = {30'h0000_0000, mode_reg};
			cnt_cfg_pkg::IDX_CMD:      rd_val = 32'h0000_0000;
			cnt_cfg_pkg::IDX_COUNT0:   rd_val = count0;
			cnt_cfg_pkg::IDX_COUNT1:   rd_val = count1;
			cnt_cfg_pkg::IDX_STATUS:   rd_val = {30'h0000_0000, done_sticky_reg};
			default:                   hit = 1'b0;
		endcase
		if (paddr[11:10] != 2'b00) begin
			hit = 1'b0;
		end
	end

	always_comb begin
		filter_next      = filter_reg;
		timebase_next    = timebase_reg;
		gate0_next       = gate0_reg;
		gate1_next       = gate1_reg;
		roll0_next       = roll0_reg;
		roll1_next       = roll1_reg;
		preset0_next     = preset0_reg;
		preset1_next     = preset1_reg;
		mode_next        = mode_reg;
		load_next        = 1'b0;
		done_sticky_next = done_sticky_reg;
		// answer comes one cycle after setup, so every access has one wait-free access cycle
		pready_next      = rd_go;
		pslverr_next     = rd_go && !hit;
		prdata_next      = (rd_go && !pwrite && hit) ? rd_val : 32'h0000_0000;
		if (wr_go) begin
			case (idx)
				cnt_cfg_pkg::IDX_FILTER:   filter_next = {1'b0, pwdata[14:0]};
				cnt_cfg_pkg::IDX_TIMEBASE: timebase_next = pwdata[15:0];
				cnt_cfg_pkg::IDX_GATE0:    gate0_next = pwdata[15:0];
				cnt_cfg_pkg::IDX_GATE1:    gate1_next = pwdata[15:0];
				cnt_cfg_pkg::IDX_ROLL0:    roll0_next = pwdata;
				cnt_cfg_pkg::IDX_ROLL1:    roll1_next = pwdata;
				cnt_cfg_pkg::IDX_PRESET0:  preset0_next = pwdata;
				cnt_cfg_pkg::IDX_PRESET1:  preset1_next = pwdata;
				cnt_cfg_pkg::IDX_MODE:     mode_next = pwdata[1:0];
				cnt_cfg_pkg::IDX_CMD:      load_next = pwdata[cnt_cfg_pkg::CMD_PRESET];
				cnt_cfg_pkg::IDX_STATUS:   done_sticky_next = done_sticky_reg & ~pwdata[1:0];
				default:                   load_next = 1'b0;
			endcase
		end
		// set wins over a clear in the same cycle
		done_sticky_next = done_sticky_next | gate_done;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filter_reg      <= cnt_cfg_pkg::FILTER_RST;
			timebase_reg    <= cnt_cfg_pkg::TIMEBASE_RST;
			gate0_reg       <= cnt_cfg_pkg::GATE_RST;
			gate1_reg       <= cnt_cfg_pkg::GATE_RST;
			roll0_reg       <= cnt_cfg_pkg::ROLL_RST;
			roll1_reg       <= cnt_cfg_pkg::ROLL_RST;
			preset0_reg     <= cnt_cfg_pkg::PRESET_RST;
			preset1_reg     <= cnt_cfg_pkg::PRESET_RST;
			mode_reg        <= 2'b00;
			load_reg        <= 1'b0;
			done_sticky_reg <= 2'b00;
			prdata          <= 32'h0000_0000;
			pready          <= 1'b0;
			pslverr         <= 1'b0;
		end else begin
			filter_reg      <= filter_next;
			timebase_reg    <= timebase_next;
			gate0_reg       <= gate0_next;
			gate1_reg       <= gate1_next;
			roll0_reg       <= roll0_next;
			roll1_reg       <= roll1_next;
			preset0_reg     <= preset0_next;
			preset1_reg     <= preset1_next;
			mode_reg        <= mode_next;
			load_reg        <= load_next;
			done_sticky_reg <= done_sticky_next;
			prdata          <= prdata_next;
			pready          <= pready_next;
			pslverr         <= pslverr_next;
		end
	end

	// ==========================================
	// input filters: six inputs, one loop
	logic [5:0] raw_in;
	logic [5:0] flt_out;
	logic [5:0] route_en;
	logic [3:0] code [1:0];

	assign raw_in = {chan_in[1].a, chan_in[1].b, chan_in[1].index,
	                 chan_in[0].a, chan_in[0].b, chan_in[0].index};
	assign code[0] = filter_reg[cnt_cfg_pkg::FLT_CH0_LSB +: 4];
	assign code[1] = filter_reg[cnt_cfg_pkg::FLT_CH1_LSB +: 4];
	assign route_en = {2{filter_reg[cnt_cfg_pkg::FLT_A_EN], filter_reg[cnt_cfg_pkg::FLT_B_EN],
	                     filter_reg[cnt_cfg_pkg::FLT_Z_EN]}};

	for (genvar g = 0; g < 6; g++) begin : g_flt
		logic        s1_reg, s2_reg, out_reg, out_next;
		logic [19:0] stab_reg, stab_next;
		logic [19:0] limit;
		logic        use_flt;

		always_comb begin
			// lowest set bit wins should software break the one-hot rule
			limit   = 20'd0;
			use_flt = route_en[g];
			if (code[g/3][0]) begin
				limit = 20'(cnt_cfg_pkg::FLT50K_CYCLES);
			end else if (code[g/3][1]) begin
				limit = 20'(FLT5K_CYCLES);
			end else if (code[g/3][2]) begin
				limit = 20'(FLT500_CYCLES);
			end else if (code[g/3][3]) begin
				limit = 20'(FLT50_CYCLES);
			end else begin
				use_flt = 1'b0;
			end
			stab_next = 20'd0;
			out_next  = out_reg;
			if (!use_flt) begin
				out_next = s2_reg;
			end else if (s2_reg != out_reg) begin
				stab_next = stab_reg + 20'd1;
				if (stab_next >= limit) begin
					out_next  = s2_reg;
					stab_next = 20'd0;
				end
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				s1_reg   <= 1'b0;
				s2_reg   <= 1'b0;
				out_reg  <= 1'b0;
				stab_reg <= 20'd0;
			end else begin
				s1_reg   <= raw_in[g];
				s2_reg   <= s1_reg;
				out_reg  <= out_next;
				stab_reg <= stab_next;
			end
		end
		assign flt_out[g] = out_reg;
	end

	assign chan_filtered[0] = '{a: flt_out[2], b: flt_out[1], index: flt_out[0]};
	assign chan_filtered[1] = '{a: flt_out[5], b: flt_out[4], index: flt_out[3]};

	// ==========================================
	// shared time base and per-channel gates
	logic [16:0] ms_reg, ms_next;
	logic [15:0] tb_cnt_reg, tb_cnt_next;
	logic        base_tick_reg, base_tick_next;
	logic [15:0] tb_eff;
	logic [15:0] gcnt_reg [1:0];
	logic [15:0] gcnt_next [1:0];
	logic [1:0]  done_next;
	logic [15:0] gint [1:0];

	assign gint[0] = gate0_reg;
	assign gint[1] = gate1_reg;

	always_comb begin
		tb_eff = (timebase_reg < cnt_cfg_pkg::TIMEBASE_MIN_MS) ?
		         cnt_cfg_pkg::TIMEBASE_MIN_MS : timebase_reg;
		ms_next        = ms_reg + 17'd1;
		tb_cnt_next    = tb_cnt_reg;
		base_tick_next = 1'b0;
		if (ms_reg >= 17'(MS_CYCLES - 1)) begin
			ms_next     = 17'd0;
			tb_cnt_next = tb_cnt_reg + 16'd1;
			if (tb_cnt_reg >= tb_eff - 16'd1) begin
				tb_cnt_next    = 16'd0;
				base_tick_next = 1'b1;
			end
		end
		for (int c = 0; c < 2; c++) begin
			gcnt_next[c] = gcnt_reg[c];
			done_next[c] = 1'b0;
			// a zero interval leaves the gate idle
			if (gint[c] == 16'd0) begin
				gcnt_next[c] = 16'd0;
			end else if (base_tick_reg) begin
				gcnt_next[c] = gcnt_reg[c] + 16'd1;
				if (gcnt_reg[c] >= gint[c] - 16'd1) begin
					gcnt_next[c] = 16'd0;
					done_next[c] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_reg        <= 17'd0;
			tb_cnt_reg    <= 16'd0;
			base_tick_reg <= 1'b0;
			gcnt_reg[0]   <= 16'd0;
			gcnt_reg[1]   <= 16'd0;
			gate_done     <= 2'b00;
		end else begin
			ms_reg        <= ms_next;
			tb_cnt_reg    <= tb_cnt_next;
			base_tick_reg <= base_tick_next;
			gcnt_reg[0]   <= gcnt_next[0];
			gcnt_reg[1]   <= gcnt_next[1];
			gate_done     <= done_next;
		end
	end

	// ==========================================
	// counters: rising A counts, B high picks down
	logic [1:0]  a_last_reg, a_last_next;
	logic [31:0] cnt_next [1:0];
	logic [31:0] cnt_cur [1:0];
	logic [31:0] lim [1:0];
	logic [31:0] pre [1:0];

	assign cnt_cur[0] = count0;
	assign cnt_cur[1] = count1;
	assign lim[0]     = roll0_reg;
	assign lim[1]     = roll1_reg;
	assign pre[0]     = preset0_reg;
	assign pre[1]     = preset1_reg;

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			logic wrap_on;
			wrap_on        = 1'b0;
			a_last_next[c] = chan_filtered[c].a;
			cnt_next[c]    = cnt_cur[c];
			// rate modes and a zero limit count freely over 32 bits
			wrap_on = (lim[c] != 32'h0000_0000) && !mode_reg[c];
			if (load_reg) begin
				cnt_next[c] = pre[c];
			end else if (chan_filtered[c].a && !a_last_reg[c]) begin
				if (!chan_filtered[c].b) begin
					cnt_next[c] = cnt_cur[c] + 32'd1;
					if (wrap_on && cnt_cur[c] >= lim[c] - 32'd1) begin
						cnt_next[c] = 32'h0000_0000;
					end
				end else begin
					cnt_next[c] = cnt_cur[c] - 32'd1;
					if (wrap_on && (cnt_cur[c] == 32'h0000_0000 || cnt_cur[c] >= lim[c])) begin
						cnt_next[c] = lim[c] - 32'd1;
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_last_reg <= 2'b00;
			count0     <= 32'h0000_0000;
			count1     <= 32'h0000_0000;
		end else begin
			a_last_reg <= a_last_next;
			count0     <= cnt_next[0];
			count1     <= cnt_next[1];
		end
	end
endmodule

// File: shared/cnt_cfg_pkg.sv
// constants and types for the counter input configuration block
package cnt_cfg_pkg;
	// ==========================================
	// register indices (byte address = index * 4)
	localparam logic [7:0] IDX_FILTER   = 8'h01;
	localparam logic [7:0] IDX_TIMEBASE = 8'h02;
	localparam logic [7:0] IDX_GATE0    = 8'h03;
	localparam logic [7:0] IDX_GATE1    = 8'h04;
	localparam logic [7:0] IDX_RSVD     = 8'h05;
	localparam logic [7:0] IDX_ROLL0    = 8'h06;
	localparam logic [7:0] IDX_ROLL1    = 8'h08;
	localparam logic [7:0] IDX_PRESET0  = 8'h0a;
	localparam logic [7:0] IDX_PRESET1  = 8'h0c;
	localparam logic [7:0] IDX_MODE     = 8'h10;
	localparam logic [7:0] IDX_CMD      = 8'h11;
	localparam logic [7:0] IDX_COUNT0   = 8'h12;
	localparam logic [7:0] IDX_COUNT1   = 8'h13;
	localparam logic [7:0] IDX_STATUS   = 8'h14;
	// ==========================================
	// field positions
	localparam int FLT_CH0_LSB  = 0;
	localparam int FLT_CH1_LSB  = 8;
	localparam int FLT_A_EN     = 12;
	localparam int FLT_B_EN     = 13;
	localparam int FLT_Z_EN     = 14;
	localparam int MODE_RATE0   = 0;
	localparam int MODE_RATE1   = 1;
	localparam int CMD_PRESET   = 0;
	// ==========================================
	// reset values
	localparam logic [15:0] FILTER_RST   = 16'h0000;
	localparam logic [15:0] TIMEBASE_RST = 16'h000a;
	localparam logic [15:0] GATE_RST     = 16'h0000;
	localparam logic [31:0] ROLL_RST     = 32'h0000_0000;
	localparam logic [31:0] PRESET_RST   = 32'h0000_0000;
	// ==========================================
	// timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int MS_NS          = 1000000;
	localparam int MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
	localparam int FLT50K_NS      = 10000;
	localparam int FLT5K_NS       = 100000;
	localparam int FLT500_NS      = 1000000;
	localparam int FLT50_NS       = 10000000;
	localparam int FLT50K_CYCLES  = FLT50K_NS / CLK_PERIOD_NS;
	localparam int FLT5K_CYCLES   = FLT5K_NS / CLK_PERIOD_NS;
	localparam int FLT500_CYCLES  = FLT500_NS / CLK_PERIOD_NS;
	localparam int FLT50_CYCLES   = FLT50_NS / CLK_PERIOD_NS;
	localparam logic [15:0] TIMEBASE_MIN_MS = 16'd10;
	// ==========================================
	// carriers
	typedef struct packed {
		logic a;
		logic b;
		logic index;
	} chan_in_t;
endpackage

// File: test/counter_input_config_properties.sv
// checker for the counter input configuration block
`timescale 1ns/1ps
module counter_input_config_properties #(
	parameter int MS_CYCLES    = 10,
	parameter int FLT5K_CYCLES = 20
) (
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [11:0]                 paddr,
	input wire logic [31:0]                 pwdata,
	input wire logic [31:0]                 prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire cnt_cfg_pkg::chan_in_t [1:0] chan_in,
	input wire cnt_cfg_pkg::chan_in_t [1:0] chan_filtered,
	input wire logic [1:0]                  gate_done,
	input wire logic [31:0]                 count0,
	input wire logic [31:0]                 count1
);
	// ====
	// shadow of written words, no reset values kept
	logic [31:0] sh_reg [0:31];
	logic [31:0] stab_reg, gcnt_reg, lim, per;
	logic        gval_reg, wr, cmd, flt;
	assign wr = psel && penable && pready && pwrite && !pslverr;
	assign cmd = wr && paddr[9:2] == cnt_cfg_pkg::IDX_CMD && pwdata[0];
	assign lim = sh_reg[6];
	assign flt = sh_reg[1][12] && sh_reg[1][3:0] != 4'h0;
	assign per = sh_reg[3] * ((sh_reg[2] < 32'd10) ? 32'd10 : sh_reg[2]) * MS_CYCLES;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 32; i++) sh_reg[i] <= '0;
			stab_reg <= '0;
			gcnt_reg <= '0;
			gval_reg <= 1'b0;
		end else begin
			if (wr && paddr[9:7] == 3'd0) sh_reg[paddr[6:2]] <= pwdata;
			stab_reg <= $changed(chan_in[0].a) ? 32'd0 : stab_reg + 32'd1;
			gcnt_reg <= gate_done[0] ? 32'd1 : gcnt_reg + 32'd1;
			// any write may move the gate phase
			gval_reg <= gate_done[0] || (gval_reg && !wr);
		end
	end
	// ====
	// assertions
	a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready) else $error("no pready after setup");
	a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready) else $error("pready longer than one cycle");
	a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
		pready && paddr[11:10] != 2'b00 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		pready && !pwrite && paddr[11:2] == 10'h005 |-> prdata == 32'h0 && !pslverr)
		else $error("reserved word not zero");
	a_filter_top_zero: assert property (@(posedge pclk) disable iff (!presetn)
		pready && !pwrite && paddr[11:2] == 10'h001 |-> prdata[31:15] == 17'h0)
		else $error("filter word upper bits set");
	a_filter_hold_time: assert property (@(posedge pclk) disable iff (!presetn)
		flt && $changed(chan_filtered[0].a) |-> stab_reg >= FLT5K_CYCLES)
		else $error("filtered level changed too early");
	a_wrap_step: assert property (@(posedge pclk) disable iff (!presetn)
		lim != 0 && !sh_reg[16][0] && !$past(cmd) && !$past(cmd, 2) && !$past(cmd, 3)
		&& $changed(count0) && ($past(count0) == lim - 1 || $past(count0) == 0)
		|-> count0 == 0 || count0 == lim - 1 || count0 == 1 || count0 == lim - 2)
		else $error("counter wrap wrong");
	a_preset_load: assert property (@(posedge pclk) disable iff (!presetn)
		cmd |-> ##[1:3] count0 == sh_reg[10] && count1 == sh_reg[12])
		else $error("preset not loaded");
	a_gate_period: assert property (@(posedge pclk) disable iff (!presetn)
		gate_done[0] && gval_reg |-> gcnt_reg == per) else $error("gate period wrong");
endmodule
bind counter_input_config counter_input_config_properties #(.MS_CYCLES(MS_CYCLES),
	.FLT5K_CYCLES(FLT5K_CYCLES)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .chan_in(chan_in), .chan_filtered(chan_filtered),
	.gate_done(gate_done), .count0(count0), .count1(count1));

// File: test/quad_source.sv
// behavioural pulse and direction source for both channels
`timescale 1ns/1ps
module quad_source (
	input  wire logic                   pclk,
	input  wire logic                   start,
	input  wire logic                   down,
	input  wire logic [7:0]             steps,
	input  wire logic [7:0]             hold,
	output cnt_cfg_pkg::chan_in_t [1:0] pins,
	output logic                        busy
);
	initial begin
		pins = '0;
		busy = 1'b0;
	end
	// ====
	// direction settles a whole hold before the first edge
	always begin
		@(posedge pclk);
		if (start) begin
			busy <= 1'b1;
			pins <= {2{1'b0, down, 1'b0}};
			repeat (hold) @(posedge pclk);
			for (int i = 0; i < steps; i++) begin
				pins <= {2{1'b1, down, 1'b1}};
				repeat (hold) @(posedge pclk);
				pins <= {2{1'b0, down, 1'b0}};
				repeat (hold) @(posedge pclk);
			end
			busy <= 1'b0;
		end
	end
endmodule

// File: test/test_counter_input_config.sv
// self-checking testbench for the counter input configuration block
`timescale 1ns/1ps
module test_counter_input_config;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic start = 1'b0, down = 1'b0, busy, pready, pslverr;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, count0, count1, v;
	logic [7:0] steps = '0, hold = '0;
	logic [1:0] gate_done;
	logic [32:0] exp_q [$];
	logic [7:0] ix [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0a, 8'h0c};
	logic [3:0] fc [7] = '{4'h0, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8};
	logic [7:0] fh [7] = '{8'd10, 8'd10, 8'd30, 8'd30, 8'd50, 8'd50, 8'd90};
	cnt_cfg_pkg::chan_in_t [1:0] chan_in, chan_filtered;
	int fails = 0, check_count = 0;
	always #5 pclk = ~pclk;
	counter_input_config #(.MS_CYCLES(10), .FLT5K_CYCLES(20), .FLT500_CYCLES(40),
		.FLT50_CYCLES(80)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_in(chan_in),
		.chan_filtered(chan_filtered), .gate_done(gate_done), .count0(count0),
		.count1(count1));
	quad_source src (.pclk(pclk), .start(start), .down(down), .steps(steps), .hold(hold),
		.pins(chan_in), .busy(busy));
	// ====
	// tasks
	task automatic check(input string nm, input logic [32:0] e, input logic [32:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		xfer(1'b1, {2'b00, i, 2'b00}, d);
	endtask
	task automatic rdv(input logic [7:0] i, input logic [31:0] e);
		exp_q.push_back({1'b0, e});
		xfer(1'b0, {2'b00, i, 2'b00}, 32'h0);
	endtask
	task automatic pulses(input logic dn, input logic [7:0] n, input logic [7:0] h);
		start <= 1'b1;
		down <= dn;
		steps <= n;
		hold <= h;
		@(posedge pclk);
		start <= 1'b0;
		do @(posedge pclk); while (busy);
		repeat (8) @(posedge pclk);
	endtask
	task automatic gate(input int ch, input logic [31:0] e);
		logic [31:0] n;
		n = 0;
		do @(posedge pclk); while (gate_done[ch] !== 1'b1);
		do begin
			@(posedge pclk);
			n++;
		end while (gate_done[ch] !== 1'b1);
		check("gate period", {1'b0, e}, {1'b0, n});
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ====
	// read monitor, oldest note first
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite)
			check($sformatf("addr %h", paddr), exp_q.pop_front(), {pslverr, prdata});
	end
	initial begin
		repeat (60000) @(posedge pclk);
		fails++;
		results();
	end
	initial begin
		v = $urandom(38880);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (ix[i]) rdv(ix[i], ix[i] == 8'h02 ? 32'ha : 32'h0);
		exp_q.push_back({1'b1, 32'h0});
		xfer(1'b0, 12'h800, 32'h0);
		$display("test reset values done");
		foreach (ix[i]) begin
			v = $urandom;
			case (ix[i])
				8'h01: v = (32'h1 << v[1:0]) | (32'h100 << v[3:2]) | {v[6:4], 12'h0};
				8'h02: v = 32'd10 + v % 32'd291;
				8'h03, 8'h04: v = v % 32'd11;
				default: v = v % 32'd16777217;
			endcase
			wr(ix[i], v);
			rdv(ix[i], ix[i] == 8'h05 ? 32'h0 : v);
		end
		$display("test register access done");
		wr(8'h01, 32'h0);
		wr(8'h03, 32'h0);
		wr(8'h04, 32'h0);
		wr(8'h06, 32'd5);
		wr(8'h08, 32'd1000);
		wr(8'h0a, 32'd0);
		wr(8'h0c, 32'd998);
		wr(8'h11, 32'h1);
		rdv(8'h12, 32'd0);
		rdv(8'h13, 32'd998);
		pulses(1'b0, 8'd7, 8'd5);
		rdv(8'h12, 32'd2);
		rdv(8'h13, 32'd5);
		check("count0 pin", {1'b0, 32'd2}, {1'b0, count0});
		pulses(1'b1, 8'd4, 8'd5);
		rdv(8'h12, 32'd3);
		rdv(8'h13, 32'd1);
		$display("test rollover done");
		wr(8'h10, 32'h3);
		wr(8'h0a, 32'd3);
		wr(8'h11, 32'h1);
		pulses(1'b0, 8'd4, 8'd5);
		rdv(8'h12, 32'd7);
		rdv(8'h13, 32'd1002);
		wr(8'h10, 32'h0);
		wr(8'h0a, 32'd0);
		$display("test rate mode done");
		for (int i = 0; i < 7; i++) begin
			wr(8'h01, {16'h0, 4'h7, fc[i], 4'h0, fc[i]});
			wr(8'h11, 32'h1);
			pulses(1'b0, 8'd2, fh[i]);
			rdv(8'h12, i % 2 == 0 ? 32'd2 : 32'd0);
		end
		$display("test filters done");
		wr(8'h02, 32'd5);
		wr(8'h03, 32'd2);
		wr(8'h04, 32'd3);
		gate(0, 32'd200);
		gate(1, 32'd300);
		wr(8'h02, 32'd12);
		gate(0, 32'd240);
		rdv(8'h14, 32'h3);
		wr(8'h03, 32'h0);
		wr(8'h04, 32'h0);
		wr(8'h14, 32'h3);
		rdv(8'h14, 32'h0);
		$display("test gates done");
		results();
	end
endmodule
